//--- hw/usc_pkg.sv
// constants, register map and field layout of the uart serial channel
//
// Summary of operation
// - txbuf write alone starts a frame
// - frame fully shifted raises tx done pulse
// - start accepted only after low exceeds half bit
// - start clears bit counter; frame end pulses rx
// - tx and rx run independently, same format
// - uart mode: frame mode sets bit count
// - mode 00/01/10/11: 7+1, 7+2, 8+1, 8+2
// - no-parity drops bit; 00 zero, 01 one
// - parity 10 odd ones, 11 even ones
// - order: start, data, parity, stop bits
// - rx pin input only; tx pin both ways
// - input select picks pin; direction turns tx in single-pin mode
// - rx done copies shifter, sets full flag
// - reading rx buffer clears full flag
// - rx busy set at start, cleared at done
// - clearing serial input enable drops rx busy
// - txbuf write sets busy; done clears it
// - busy stays set while data pending
// - clearing serial output enable drops tx busy
// - break sends every frame bit as zero
// - pending data follows current frame without gap
package usc_pkg;
	localparam int          ADDR_W      = 5;
	localparam logic [4:0]  OFF_MODE    = 5'h00; // serial_mode_reg0
	localparam logic [4:0]  OFF_DIV     = 5'h04; // clocks per bit
	localparam logic [4:0]  OFF_TXBUF   = 5'h08; // tx_holding_buffer
	localparam logic [4:0]  OFF_RXBUF   = 5'h0C; // rx_holding_buffer
	localparam logic [4:0]  OFF_STATUS  = 5'h10; // serial_status_reg
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [11:0] MODE_RESET  = 12'h000;
	localparam logic [15:0] DIV_RESET   = 16'h1046; // 9600 bit/s at 40 MHz
	localparam int          ST_RXFULL   = 0;
	localparam int          ST_RXBUSY   = 1;
	localparam int          ST_TXBUSY   = 2;
	localparam int          ST_TXPEND   = 3;
	localparam int          FRAME_W     = 12;
	localparam logic [3:0]  LEN_BASE    = 4'h1; // the start bit

	// mode register layout, bit 0 is comm_type_select
	typedef struct packed {
		logic       break_send_enable;
		logic [1:0] parity_mode;
		logic       no_parity_select;
		logic [1:0] frame_mode;     // [1] eight data bits, [0] two stops
		logic       port_direction; // tx pin drives in single-pin mode
		logic       input_pin_select;
		logic       serial_in_enable;
		logic       serial_out_enable;
		logic       clock_master_select;
		logic       comm_type_select;
	} usc_mode_s;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b001,
		RX_START = 3'b010,
		RX_BITS  = 3'b100
	} usc_rx_e;
endpackage

//--- hw/usc_uart.sv
// uart serial channel with axi4-lite register access
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module usc_uart
	import usc_pkg::*;
(
	input  wire logic              clock_i,
	input  wire logic              nrst_i,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	input  wire logic              rxd_i,
	input  wire logic              txd_i,
	output logic                   txd_o,
	output logic                   txd_oe_o,
	output logic                   tx_done_irq_o,
	output logic                   rx_done_irq_o
);
	// byte-lane merge for writable registers
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction

	// builds the serial frame lsb first and its bit count
	function automatic logic [FRAME_W+3:0] build_frame(input logic [7:0] d, input usc_mode_s m);
		logic [FRAME_W-1:0] f;
		logic [3:0]         n;
		logic               ones;
		logic               par;
		f = '1;
		f[0] = 1'b0;
		ones = m.frame_mode[1] ? ^d : ^d[6:0];
		case (m.parity_mode)
			2'b00:   par = 1'b0;
			2'b01:   par = 1'b1;
			2'b10:   par = ~ones;
			default: par = ones;
		endcase
		for (int i = 0; i < 8; i++)
			if (i < 7 || m.frame_mode[1])
				f[1+i] = d[i];
		n = m.frame_mode[1] ? 4'h9 : 4'h8;
		if (!m.no_parity_select)
		begin
			f[n] = par;
			n = n + 4'h1;
		end
		n = n + (m.frame_mode[0] ? 4'h2 : 4'h1);
		if (m.break_send_enable)
			f = '0;
		return {n, f};
	endfunction

	logic [11:0] mode_reg;
	logic [15:0] div_reg;
	logic [7:0]  tx_hold_reg;
	logic [7:0]  rx_hold_reg;
	logic        aw_have_reg, w_have_reg;
	logic [4:0]  aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [1:0]  bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic [2:0]  sync_reg [2];
	logic [1:0]  filt_reg;
	logic        tx_active_reg, tx_pend_reg, tx_busy_reg, tx_done_reg;
	logic [FRAME_W-1:0] tx_shift_reg;
	logic [3:0]  tx_left_reg;
	logic [15:0] tx_cnt_reg;
	logic        txd_reg, txd_oe_reg;
	usc_rx_e     rx_state_reg, rx_state_next;
	logic [15:0] rx_cnt_reg, rx_cnt_next;
	logic [3:0]  rx_idx_reg, rx_idx_next;
	logic [9:0]  rx_bits_reg, rx_bits_next;
	logic        rx_busy_reg, rx_full_reg, rx_done_reg;

	usc_mode_s mode;
	assign mode = usc_mode_s'(mode_reg);

	// bus decode
	wire        wr_fire  = aw_have_reg && w_have_reg && !bvalid_reg;
	wire        wr_map   = aw_addr_reg == OFF_MODE || aw_addr_reg == OFF_DIV || aw_addr_reg == OFF_TXBUF;
	wire        rd_fire  = s_axi_arvalid_i && arready_reg;
	wire [4:0]  ra       = s_axi_araddr_i;
	wire        rd_map   = ra == OFF_MODE || ra == OFF_DIV || ra == OFF_TXBUF || ra == OFF_RXBUF || ra == OFF_STATUS;
	wire        rx_read  = rd_fire && ra == OFF_RXBUF;
	wire [31:0] status_w = {28'h000_0000, tx_pend_reg, tx_busy_reg, rx_busy_reg, rx_full_reg};
	wire [31:0] rd_mux   = ra == OFF_MODE  ? {20'h0_0000, mode_reg} :
	                       ra == OFF_DIV   ? {16'h0000, div_reg} :
	                       ra == OFF_TXBUF ? {24'h00_0000, tx_hold_reg} :
	                       ra == OFF_RXBUF ? {24'h00_0000, rx_hold_reg} :
	                       ra == OFF_STATUS ? status_w : 32'h0000_0000;
	wire [31:0] mode_new = wmerge({20'h0_0000, mode_reg}, w_data_reg, w_strb_reg);
	wire [31:0] div_new  = wmerge({16'h0000, div_reg}, w_data_reg, w_strb_reg);

	// axi4-lite write channels, address and data taken in either order
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			aw_addr_reg <= 5'h00;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid_i && awready_reg)
			begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_i;
				awready_reg <= 1'b0;
			end
			if (s_axi_wvalid_i && wready_reg)
			begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata_i;
				w_strb_reg <= s_axi_wstrb_i;
				wready_reg <= 1'b0;
			end
			if (wr_fire)
			begin
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_map ? RESP_OKAY : RESP_SLVERR;
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
			end
			if (bvalid_reg && s_axi_bready_i)
			begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// axi4-lite read channel, data registered one cycle after the address
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_mux;
			rresp_reg   <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_reg && s_axi_rready_i)
		begin
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// configuration registers
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			mode_reg <= MODE_RESET;
			div_reg  <= DIV_RESET;
		end
		else if (wr_fire)
		begin
			if (aw_addr_reg == OFF_MODE)
				mode_reg <= mode_new[11:0];
			if (aw_addr_reg == OFF_DIV)
				div_reg <= div_new[15:0];
		end
	end

	// pin synchronisers: a level counts once stages two and three agree
	wire [1:0] pin_w = {txd_i, rxd_i};
	for (genvar p = 0; p < 2; p++)
	begin : g_sync
		always_ff @(posedge clock_i or negedge nrst_i)
		begin
			if (!nrst_i)
			begin
				sync_reg[p] <= 3'b111;
				filt_reg[p] <= 1'b1;
			end
			else
			begin
				sync_reg[p] <= {sync_reg[p][1:0], pin_w[p]};
				if (sync_reg[p][1] == sync_reg[p][2])
					filt_reg[p] <= sync_reg[p][2];
			end
		end
	end

	// channel enables; clock master must be set or nothing moves
	wire        uart_on = mode.comm_type_select && mode.clock_master_select;
	wire        tx_ena  = uart_on && mode.serial_out_enable;
	wire        rx_ena  = uart_on && mode.serial_in_enable;
	wire [15:0] div_m1  = div_reg - 16'h0001;
	wire [15:0] half    = {1'b0, div_reg[15:1]};

	// transmitter sequencing
	wire                 tx_wr     = wr_fire && aw_addr_reg == OFF_TXBUF && w_strb_reg[0] && tx_ena;
	wire                 tx_bitend = tx_active_reg && tx_cnt_reg == div_m1;
	wire                 tx_last   = tx_bitend && tx_left_reg == 4'h1;
	wire                 tx_load   = tx_ena && tx_pend_reg && (!tx_active_reg || tx_last);
	wire [FRAME_W+3:0]   frame_w   = build_frame(tx_hold_reg, mode);

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			tx_hold_reg   <= 8'h00;
			tx_pend_reg   <= 1'b0;
			tx_busy_reg   <= 1'b0;
			tx_active_reg <= 1'b0;
			tx_shift_reg  <= '1;
			tx_left_reg   <= 4'h0;
			tx_cnt_reg    <= 16'h0000;
			tx_done_reg   <= 1'b0;
		end
		else
		begin
			if (tx_wr)
				tx_hold_reg <= w_data_reg[7:0];
			tx_pend_reg <= tx_ena && (tx_wr || (tx_pend_reg && !tx_load));
			if (!tx_ena)
				tx_busy_reg <= 1'b0;
			else if (tx_wr)
				tx_busy_reg <= 1'b1;
			else if (tx_last && !tx_pend_reg)
				tx_busy_reg <= 1'b0;
			tx_done_reg <= tx_last && tx_ena;
			if (!tx_ena)
				tx_active_reg <= 1'b0;
			else if (tx_load)
				tx_active_reg <= 1'b1;
			else if (tx_last)
				tx_active_reg <= 1'b0;
			if (tx_load)
			begin
				tx_shift_reg <= frame_w[FRAME_W-1:0];
				tx_left_reg  <= frame_w[FRAME_W+3:FRAME_W];
			end
			else if (tx_bitend)
			begin
				tx_shift_reg <= {1'b1, tx_shift_reg[FRAME_W-1:1]};
				tx_left_reg  <= tx_left_reg - 4'h1;
			end
			tx_cnt_reg <= (tx_load || tx_bitend || !tx_active_reg) ? 16'h0000 : tx_cnt_reg + 16'h0001;
		end
	end

	// pin drive: line high when idle, direction bit owns the pin in single-pin mode
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			txd_reg    <= 1'b1;
			txd_oe_reg <= 1'b0;
		end
		else
		begin
			txd_reg    <= (tx_active_reg && tx_ena) ? tx_shift_reg[0] : 1'b1;
			txd_oe_reg <= mode.input_pin_select ? mode.port_direction : mode.serial_out_enable;
		end
	end

	// receiver
	wire       rx_line = mode.input_pin_select ? filt_reg[1] : filt_reg[0];
	wire [3:0] rx_need = (mode.frame_mode[1] ? 4'h8 : 4'h7) + (mode.no_parity_select ? 4'h0 : 4'h1) + 4'h1;
	wire       rx_acc  = rx_state_reg == RX_START && rx_ena && !rx_line && rx_cnt_reg == half;
	wire       rx_samp = rx_state_reg == RX_BITS && rx_ena && rx_cnt_reg == div_m1;
	wire       rx_end  = rx_samp && rx_idx_reg == rx_need - 4'h1;

	always_comb
	begin
		rx_state_next = rx_state_reg;
		rx_cnt_next   = rx_cnt_reg + 16'h0001;
		rx_idx_next   = rx_idx_reg;
		rx_bits_next  = rx_bits_reg;
		case (rx_state_reg)
			RX_IDLE:
			begin
				rx_cnt_next = 16'h0000;
				if (rx_ena && !rx_line)
					rx_state_next = RX_START;
			end
			RX_START:
			begin
				if (!rx_ena || rx_line)
					rx_state_next = RX_IDLE;
				else if (rx_acc)
				begin
					rx_state_next = RX_BITS;
					rx_cnt_next   = 16'h0000;
					rx_idx_next   = 4'h0;
				end
			end
			RX_BITS:
			begin
				if (!rx_ena)
					rx_state_next = RX_IDLE;
				else if (rx_samp)
				begin
					rx_cnt_next             = 16'h0000;
					rx_bits_next[rx_idx_reg] = rx_line;
					rx_idx_next             = rx_idx_reg + 4'h1;
					if (rx_end)
						rx_state_next = RX_IDLE;
				end
			end
			default:
				rx_state_next = RX_IDLE;
		endcase
	end

	// receive state, buffer and flags
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rx_state_reg <= RX_IDLE;
			rx_cnt_reg   <= 16'h0000;
			rx_idx_reg   <= 4'h0;
			rx_bits_reg  <= 10'h000;
			rx_hold_reg  <= 8'h00;
			rx_busy_reg  <= 1'b0;
			rx_full_reg  <= 1'b0;
			rx_done_reg  <= 1'b0;
		end
		else
		begin
			rx_state_reg <= rx_state_next;
			rx_cnt_reg   <= rx_cnt_next;
			rx_idx_reg   <= rx_idx_next;
			rx_bits_reg  <= rx_bits_next;
			rx_done_reg  <= rx_end;
			if (rx_end)
				rx_hold_reg <= mode.frame_mode[1] ? rx_bits_next[7:0] : {1'b0, rx_bits_next[6:0]};
			if (rx_end)
				rx_full_reg <= 1'b1;
			else if (rx_read)
				rx_full_reg <= 1'b0;
			if (!rx_ena || rx_end)
				rx_busy_reg <= 1'b0;
			else if (rx_acc)
				rx_busy_reg <= 1'b1;
		end
	end

	assign s_axi_awready_o = awready_reg;
	assign s_axi_wready_o  = wready_reg;
	assign s_axi_bvalid_o  = bvalid_reg;
	assign s_axi_bresp_o   = bresp_reg;
	assign s_axi_arready_o = arready_reg;
	assign s_axi_rvalid_o  = rvalid_reg;
	assign s_axi_rdata_o   = rdata_reg;
	assign s_axi_rresp_o   = rresp_reg;
	assign txd_o           = txd_reg;
	assign txd_oe_o        = txd_oe_reg;
	assign tx_done_irq_o   = tx_done_reg;
	assign rx_done_irq_o   = rx_done_reg;

	// checks
	property p_tx_start;
		@(posedge clock_i) disable iff (!nrst_i) tx_wr && !tx_active_reg |-> ##2 tx_active_reg ##1 !txd_reg;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("tx write did not start a frame");
	property p_tx_done;
		@(posedge clock_i) disable iff (!nrst_i) tx_last && tx_ena |=> tx_done_irq_o && (txd_reg || mode.break_send_enable);
	endproperty
	a_tx_done: assert property (p_tx_done) else $error("no tx done pulse at frame end");
	property p_rx_half;
		@(posedge clock_i) disable iff (!nrst_i) $rose(rx_busy_reg) |-> $past(rx_cnt_reg) == half;
	endproperty
	a_rx_half: assert property (p_rx_half) else $error("start accepted before half bit");
	property p_rx_store;
		@(posedge clock_i) disable iff (!nrst_i) rx_end |=> rx_full_reg && rx_done_irq_o && !rx_busy_reg;
	endproperty
	a_rx_store: assert property (p_rx_store) else $error("rx done did not fill buffer");
	property p_rx_clear;
		@(posedge clock_i) disable iff (!nrst_i) rx_read && !rx_end |=> !rx_full_reg;
	endproperty
	a_rx_clear: assert property (p_rx_clear) else $error("rx read left full flag set");
	property p_rx_abort;
		@(posedge clock_i) disable iff (!nrst_i) !rx_ena |=> !rx_busy_reg && rx_state_reg != RX_BITS;
	endproperty
	a_rx_abort: assert property (p_rx_abort) else $error("rx busy survived input disable");
	property p_tx_kill;
		@(posedge clock_i) disable iff (!nrst_i) !tx_ena |=> !tx_busy_reg ##1 txd_reg;
	endproperty
	a_tx_kill: assert property (p_tx_kill) else $error("tx busy survived output disable");
	property p_tx_chain;
		@(posedge clock_i) disable iff (!nrst_i) tx_last && tx_pend_reg && tx_ena |=> tx_busy_reg && tx_active_reg;
	endproperty
	a_tx_chain: assert property (p_tx_chain) else $error("gap or busy drop in chained frames");
	property p_tx_break;
		@(posedge clock_i) disable iff (!nrst_i) tx_load && mode.break_send_enable |=> tx_shift_reg == '0;
	endproperty
	a_tx_break: assert property (p_tx_break) else $error("break frame holds a one");
endmodule
`default_nettype wire

//--- bench/usc_peer.sv
// behavioural remote uart: frame monitor on the tx pin, frame sender towards the channel
`timescale 1ns/1ps
`default_nettype none
module usc_peer
(
	input  wire logic        clock_i,
	input  wire logic [15:0] div_i,
	input  wire logic [3:0]  nbits_i,
	input  wire logic        line_i,
	output logic             ser_o
);
	logic [11:0] frame_q [$];

	// line rests high between frames
	initial ser_o = 1'b1;

	// sample each bit of a frame in its middle, start bit into bit 0
	always
	begin : mon
		logic [11:0] f;
		@(negedge line_i);
		f = '0;
		repeat (div_i / 2) @(posedge clock_i);
		for (int i = 0; i <= nbits_i; i++)
		begin
			f[i] = line_i;
			if (i < nbits_i) repeat (div_i) @(posedge clock_i);
		end
		frame_q.push_back(f);
	end

	// start, data, parity, stops lsb first, each for one bit time
	task automatic send(input logic [11:0] f, input logic [3:0] n);
		for (int i = 0; i <= n; i++)
		begin
			ser_o <= f[i];
			repeat (div_i) @(posedge clock_i);
		end
		ser_o <= 1'b1;
	endtask

	// short low pulse that should not pass for a start
	task automatic low(input int c);
		ser_o <= 1'b0;
		repeat (c) @(posedge clock_i);
		ser_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

//--- bench/usc_uart_test.sv
// self-checking bench of the uart serial channel with a remote peer
`timescale 1ns/1ps
`default_nettype none
module usc_uart_test
	import usc_pkg::*;
;
	logic              clock_i = 1'b0;
	logic              nrst_i  = 1'b0;
	logic [ADDR_W-1:0] awaddr  = '0;
	logic [ADDR_W-1:0] araddr  = '0;
	logic [31:0]       wdata   = '0;
	logic              awvalid = 1'b0;
	logic              wvalid  = 1'b0;
	logic              bready  = 1'b0;
	logic              arvalid = 1'b0;
	logic              rready  = 1'b0;
	logic              pin_sel = 1'b0;
	logic [3:0]        nb      = 4'h9;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp;
	logic [31:0]       rdata;
	logic              txd, txd_oe, tx_irq, rx_irq, ser, rxd, line;
	int                num_errors = 0;
	int                n_checks   = 0;
	int                cyc = 0, tx_cnt = 0, rx_cnt = 0, tx_t = 0, tx_gap = 0;

	// mode word, byte written, byte expected back
	localparam logic [27:0] ROWS [9] = '{28'h18F_5555, 28'h1CF_A3A3, 28'h10F_BC3C, 28'h14F_7E7E,
		28'h08F_FFFF, 28'h28F_0000, 28'h48F_5A5A, 28'h64F_5B5B, 28'h98F_FF00};

	always #12.5 clock_i = ~clock_i;

	// tx pin pulled up; in single-pin mode the peer drives it and the rx pin sits low
	assign rxd  = pin_sel ? 1'b0 : ser;
	assign line = txd_oe ? txd : (pin_sel ? ser : 1'b1);

	usc_uart i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .rxd_i(rxd), .txd_i(line),
		.txd_o(txd), .txd_oe_o(txd_oe), .tx_done_irq_o(tx_irq), .rx_done_irq_o(rx_irq));

	usc_peer i_peer (.clock_i(clock_i), .div_i(16'h0008), .nbits_i(nb), .line_i(line), .ser_o(ser));

	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// cycle count, done pulses, spacing of the last two tx pulses, hang limit
	always @(posedge clock_i)
	begin
		cyc++;
		if (tx_irq === 1'b1)
		begin
			tx_cnt++;
			tx_gap = cyc - tx_t;
			tx_t = cyc;
		end
		if (rx_irq === 1'b1) rx_cnt++;
		if (cyc == 20000)
		begin
			num_errors++;
			final_report();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// axi4-lite write: address and data together, each released when taken
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ao;
		logic wo;
		@(posedge clock_i);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		ao = 1'b1;
		wo = 1'b1;
		while (ao || wo)
		begin
			@(posedge clock_i);
			if (awready === 1'b1) ao = 1'b0;
			if (wready === 1'b1) wo = 1'b0;
			if (!ao) awvalid <= 1'b0;
			if (!wo) wvalid <= 1'b0;
		end
		do @(posedge clock_i); while (bvalid !== 1'b1);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		bready <= 1'b0;
	endtask

	// axi4-lite read, data and response taken at the rvalid edge
	task automatic rdc(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er, input string what);
		@(posedge clock_i);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clock_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clock_i); while (rvalid !== 1'b1);
		chk(what, e, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		rready <= 1'b0;
	endtask

	// wait for the tx count to reach t and rx to reach r, then both must match exactly
	task automatic wait_dn(input int t, input int r);
		int k;
		k = 0;
		while ((tx_cnt < t || rx_cnt < r) && k < 3000)
		begin
			@(posedge clock_i);
			k++;
		end
		repeat (2) @(posedge clock_i);
		chk("tx done count", t, tx_cnt);
		chk("rx done count", r, rx_cnt);
	endtask

	// expected line bits lsb first from the mode word; n is the count after the start bit
	function automatic logic [11:0] frm(input logic [11:0] md, input logic [7:0] d, output logic [3:0] n);
		logic [11:0] f;
		f = {3'h0, md[7] ? d : {1'b0, d[6:0]}, 1'b0};
		n = md[7] ? 4'h8 : 4'h7;
		if (md[8] == 1'b0)
		begin
			n = n + 4'h1;
			f[n] = md[10] ? ^f ^ ~md[9] : md[9];
		end
		n = n + (md[6] ? 4'h2 : 4'h1);
		f[n] = 1'b1;
		f[n - 4'h1] = md[6] ? 1'b1 : f[n - 4'h1];
		if (md[11]) f = '0;
		return f;
	endfunction

	// main sequence
	initial
	begin
		logic [11:0] f;
		int t0;
		int r0;
		repeat (6) @(posedge clock_i);
		nrst_i <= 1'b1;
		chk("txd idle", 32'h0000_0001, {31'h0, txd});
		rdc(OFF_MODE, {20'h0, MODE_RESET}, RESP_OKAY, "mode reset");
		rdc(OFF_DIV, {16'h0, DIV_RESET}, RESP_OKAY, "div reset");
		rdc(5'h14, 32'h0000_0000, RESP_SLVERR, "unmapped read");
		wr(5'h18, 32'h0000_0001, RESP_SLVERR);
		wr(OFF_DIV, 32'h0000_0008, RESP_OKAY);
		$display("test reset done");
		for (int k = 0; k < 9; k++)
		begin
			wr(OFF_MODE, {20'h0, ROWS[k][27:16]}, RESP_OKAY);
			f = frm(ROWS[k][27:16], ROWS[k][15:8], nb);
			t0 = tx_cnt;
			r0 = rx_cnt;
			fork
				wr(OFF_TXBUF, {24'h0, ROWS[k][15:8]}, RESP_OKAY);
				i_peer.send(f, nb);
			join
			wait_dn(t0 + 1, r0 + 1);
			chk("frame", {20'h0, f}, {20'h0, i_peer.frame_q.pop_front()});
			rdc(OFF_STATUS, 32'h0000_0001, RESP_OKAY, "status full");
			rdc(OFF_RXBUF, {24'h0, ROWS[k][7:0]}, RESP_OKAY, "rx data");
			rdc(OFF_STATUS, 32'h0000_0000, RESP_OKAY, "status read");
		end
		$display("test rows done");
		wr(OFF_MODE, 32'h0000_018F, RESP_OKAY);
		t0 = tx_cnt;
		r0 = rx_cnt;
		wr(OFF_TXBUF, 32'h0000_00C3, RESP_OKAY);
		wr(OFF_TXBUF, 32'h0000_003C, RESP_OKAY);
		rdc(OFF_STATUS, 32'h0000_000C, RESP_OKAY, "busy pending");
		wait_dn(t0 + 1, r0);
		rdc(OFF_STATUS, 32'h0000_0004, RESP_OKAY, "busy between");
		wait_dn(t0 + 2, r0);
		chk("frame gap", 32'h0000_0050, tx_gap);
		rdc(OFF_STATUS, 32'h0000_0000, RESP_OKAY, "busy end");
		chk("first", {20'h0, frm(12'h18F, 8'hC3, nb)}, {20'h0, i_peer.frame_q.pop_front()});
		chk("second", {20'h0, frm(12'h18F, 8'h3C, nb)}, {20'h0, i_peer.frame_q.pop_front()});
		$display("test back to back done");
		t0 = tx_cnt;
		wr(OFF_TXBUF, 32'h0000_00F0, RESP_OKAY);
		repeat (20) @(posedge clock_i);
		wr(OFF_MODE, 32'h0000_018B, RESP_OKAY);
		rdc(OFF_STATUS, 32'h0000_0000, RESP_OKAY, "tx busy off");
		chk("txd off", 32'h0000_0001, {31'h0, txd});
		repeat (120) @(posedge clock_i);
		chk("no tx done", t0, tx_cnt);
		i_peer.frame_q.delete();
		$display("test tx abort done");
		wr(OFF_MODE, 32'h0000_018F, RESP_OKAY);
		r0 = rx_cnt;
		i_peer.low(4);
		repeat (16) @(posedge clock_i);
		rdc(OFF_STATUS, 32'h0000_0000, RESP_OKAY, "short low");
		f = frm(12'h18F, 8'hA5, nb);
		fork
			i_peer.send(f, nb);
			begin
				repeat (24) @(posedge clock_i);
				rdc(OFF_STATUS, 32'h0000_0002, RESP_OKAY, "rx busy");
				wr(OFF_MODE, 32'h0000_0187, RESP_OKAY);
				rdc(OFF_STATUS, 32'h0000_0000, RESP_OKAY, "rx busy off");
			end
		join
		repeat (16) @(posedge clock_i);
		chk("no rx done", r0, rx_cnt);
		$display("test rx abort done");
		wr(OFF_MODE, 32'h0000_019F, RESP_OKAY);
		repeat (2) @(posedge clock_i);
		chk("oe single pin", 32'h0000_0000, {31'h0, txd_oe});
		pin_sel <= 1'b1;
		r0 = rx_cnt;
		f = frm(12'h19F, 8'h96, nb);
		i_peer.send(f, nb);
		wait_dn(tx_cnt, r0 + 1);
		rdc(OFF_RXBUF, 32'h0000_0096, RESP_OKAY, "single pin data");
		pin_sel <= 1'b0;
		wr(OFF_MODE, 32'h0000_01BF, RESP_OKAY);
		repeat (2) @(posedge clock_i);
		chk("oe turned", 32'h0000_0001, {31'h0, txd_oe});
		i_peer.frame_q.delete();
		$display("test single pin done");
		wr(OFF_MODE, 32'h0000_018D, RESP_OKAY);
		wr(OFF_TXBUF, 32'h0000_0081, RESP_OKAY);
		rdc(OFF_STATUS, 32'h0000_0000, RESP_OKAY, "no clock master");
		wr(OFF_MODE, 32'h0000_018F, RESP_OKAY);
		wr(OFF_TXBUF, 32'h0000_0081, RESP_OKAY);
		repeat (20) @(posedge clock_i);
		nrst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		chk("txd in reset", 32'h0000_0001, {31'h0, txd});
		nrst_i <= 1'b1;
		chk("oe after reset", 32'h0000_0000, {31'h0, txd_oe});
		rdc(OFF_MODE, {20'h0, MODE_RESET}, RESP_OKAY, "mode after reset");
		rdc(OFF_STATUS, 32'h0000_0000, RESP_OKAY, "status after reset");
		i_peer.frame_q.delete();
		$display("test mid reset done");
		final_report();
	end
endmodule
`default_nettype wire
